// file: core/lmx_regs.svh
// Purpose: Constants for the load, move and multiply execution block
// Assumes: 32-bit data path, 16 global and 16 local registers
// Notes:   Opcode values are in lmx_pkg; this file holds register codes, field widths and flag bits
`ifndef LMX_REGS_SVH
`define LMX_REGS_SVH

`define LMX_REG_PC        4'h0
`define LMX_REG_SR        4'h1
`define LMX_SHORT_DIS_W   13
`define LMX_LONG_DIS_W    29
`define LMX_SHORT_CON_W   15
`define LMX_LONG_CON_W    31
`define LMX_TYPE_MSB      13
`define LMX_TYPE_LSB      12
`define LMX_WORD_STEP     32'h0000_0004
`define LMX_FLAG_Z        0
`define LMX_FLAG_N        1
`define LMX_FLAG_V        2
`define LMX_MUL_CYCLES    4'h1

`endif

// file: core/lmx_pkg.sv
// Purpose: Types for the load, move and multiply execution block
// Assumes: Constants come from lmx_regs.svh
// Notes:   Operation codes are internal to the execution block
package lmx_pkg;

   typedef enum logic [3:0] {
      LMX_OP_NONE   = 4'h0,
      LMX_OP_IOA    = 4'h1,
      LMX_OP_IOD    = 4'h2,
      LMX_OP_NEXT   = 4'h3,
      LMX_OP_POSTW  = 4'h4,
      LMX_OP_INDW   = 4'h5,
      LMX_OP_STACKW = 4'h6,
      LMX_OP_MASK   = 4'h7,
      LMX_OP_MOV    = 4'h8,
      LMX_OP_COPY_PAIR_OP   = 4'h9,
      LMX_OP_COPY_IMMEDIATE_OP   = 4'hA,
      LMX_OP_MUL    = 4'hB,
      LMX_OP_SIGNED_WIDE_PRODUCT_OP   = 4'hC
   } lmx_op_e;

   typedef enum logic [2:0] {
      LMX_DT_BU = 3'h0,
      LMX_DT_BS = 3'h1,
      LMX_DT_HU = 3'h2,
      LMX_DT_HS = 3'h3,
      LMX_DT_W  = 3'h4,
      LMX_DT_D  = 3'h5
   } lmx_dtype_e;

   typedef enum logic [4:0] {
      LMX_ST_IDLE  = 5'b00001,
      LMX_ST_RD1   = 5'b00010,
      LMX_ST_RD2   = 5'b00100,
      LMX_ST_WR2   = 5'b01000,
      LMX_ST_DONE  = 5'b10000
   } lmx_state_e;

endpackage

// file: core/lmx_wb_if.sv
// Purpose: Carrier for register write-back requests between modules
// Assumes: One write per cycle
// Notes:   Index bit 4 selects the local bank
`timescale 1ns/1ps
interface lmx_wb_if;
   logic        we;
   logic [4:0]  idx;
   logic [31:0] data;
   modport src (output we, output idx, output data);
   modport dst (input we, input idx, input data);
endinterface

// file: core/lmx_regfile.sv
// Purpose: Global and local register banks with three read ports
// Assumes: Write port from lmx_wb_if
// Notes:   Index bit 4 high selects the local bank
`timescale 1ns/1ps
module lmx_regfile
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   lmx_wb_if.dst            wb,
   input  wire logic [4:0]  ra_idx,
   input  wire logic [4:0]  rb_idx,
   input  wire logic [4:0]  rc_idx,
   output      logic [31:0] ra_data,
   output      logic [31:0] rb_data,
   output      logic [31:0] rc_data
);
   logic [31:0] regs      [32];
   logic [31:0] next_regs [32];

   always_comb
   begin
      next_regs = regs;
      if (wb.we)
      begin
         next_regs[wb.idx] = wb.data;
      end
      ra_data = regs[ra_idx];
      rb_data = regs[rb_idx];
      rc_data = regs[rc_idx];
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 32; i++)
         begin
            regs[i] <= 32'h0000_0000;
         end
      end
      else if (clk_en)
      begin
         regs <= next_regs;
      end
   end
endmodule

// file: core/lmx_exec.sv
// Purpose: Executes load, mask, move and multiply operations
// Assumes: Decoded operation, fields and immediate arrive with op_valid
// Notes:   Memory returns data one or more cycles after mem_req
// Notes on behaviour
// RULE_01: s and d bits choose global or local
// RULE_02: Displacement short or long by e bit
// RULE_03: Long format takes type from D13..D12
// RULE_04: Status register destination means absolute I/O address
// RULE_05: Other destination: I/O address is register plus displacement
// RULE_06: I/O loads word or pair, second at +4
// RULE_07: Next mode loads at base, then adds displacement
// RULE_08: Next mode clears displacement bit 0 unless byte
// RULE_09: Next mode supports all six data types
// RULE_10: Post-increment word load bumps base by four
// RULE_11: Indirect word load leaves base unchanged
// RULE_12: Short format base always from local bank
// RULE_13: Stack word load adds displacement to base
// RULE_14: Mask ANDs constant, sets zero flag
// RULE_15: Mask constant short or long by e bit
// RULE_16: Move copies word, sets zero and negative
// RULE_17: Pair move writes high word first, sets flags
// RULE_18: Pair move: status source zero, counter destination returns
// RULE_19: Immediate move sets zero, negative, clears overflow
// RULE_20: Word multiply keeps low product word
// RULE_21: Signed wide multiply writes 64-bit pair
// RULE_22: Software avoids counter or status multiply operands
// RULE_23: Wide multiply flags follow whole product
// RULE_24: Narrow loads zero- or sign-extend to 32 bits
`timescale 1ns/1ps
`include "lmx_regs.svh"
module lmx_exec
(
   input  wire logic               core_clk,
   input  wire logic               resetn,
   input  wire logic               clk_en,
   input  wire logic               op_valid,
   input  wire lmx_pkg::lmx_op_e   op_code,
   input  wire logic               s_bit,
   input  wire logic               d_bit,
   input  wire logic               e_bit,
   input  wire logic [3:0]         rs_code,
   input  wire logic [3:0]         rd_code,
   input  wire logic [27:0]        dis_field,
   input  wire logic [30:0]        const_field,
   input  wire logic [1:0]         short_type,
   input  wire logic [31:0]        imm_value,
   output      logic               busy,
   output      logic               mem_req,
   output      logic               mem_io,
   output      logic [31:0]        mem_addr,
   input  wire logic               mem_ack,
   input  wire logic [31:0]        mem_rdata,
   output      logic [2:0]         flags,
   output      logic               ret_req,
   output      logic [31:0]        ret_pc,
   output      logic [31:0]        ret_sr
);
   lmx_wb_if wb ();

   logic [31:0] ra_data;
   logic [31:0] rb_data;
   logic [31:0] rc_data;
   logic [4:0]  src_idx;
   logic [4:0]  dst_idx;
   logic [4:0]  srcf_idx;
   logic [4:0]  dstf_idx;
   logic [31:0] dis;
   logic [31:0] cval;
   logic [31:0] src_val;
   logic [31:0] dst_val;
   logic        short_fmt;
   logic [63:0] sprod;
   logic [63:0] uprod;
   lmx_pkg::lmx_dtype_e dtype;

   lmx_pkg::lmx_state_e state;
   lmx_pkg::lmx_state_e next_state;
   lmx_pkg::lmx_op_e    op_q;
   lmx_pkg::lmx_op_e    next_op_q;
   lmx_pkg::lmx_dtype_e dt_q;
   lmx_pkg::lmx_dtype_e next_dt_q;
   logic [4:0]  tgt_q;
   logic [4:0]  next_tgt_q;
   logic [31:0] addr_q;
   logic [31:0] next_addr_q;
   logic        io_q;
   logic        next_io_q;
   logic [31:0] hold_q;
   logic [31:0] next_hold_q;
   logic [4:0]  hidx_q;
   logic [4:0]  next_hidx_q;
   logic [2:0]  next_flags;
   logic        next_ret_req;
   logic [31:0] next_ret_pc;
   logic [31:0] next_ret_sr;
   logic        wb_we;
   logic [4:0]  wb_idx;
   logic [31:0] wb_data;

   assign short_fmt = (op_code == lmx_pkg::LMX_OP_POSTW) || (op_code == lmx_pkg::LMX_OP_INDW);
   assign src_idx   = {s_bit, rs_code};                               // [RULE_01]
   assign dst_idx   = short_fmt ? {1'b1, rd_code} : {d_bit, rd_code}; // [RULE_01] [RULE_12]
   assign srcf_idx  = {s_bit, 4'(rs_code + 4'h1)};
   assign dstf_idx  = {d_bit, 4'(rd_code + 4'h1)};

   // Sign bit replicated above short or long field
   assign dis  = e_bit ? {{(32-`LMX_LONG_DIS_W+1){dis_field[27]}}, dis_field}
                       : {{(32-`LMX_SHORT_DIS_W+1){dis_field[27]}},
                          dis_field[`LMX_SHORT_DIS_W-2:0]};            // [RULE_02]
   assign cval = e_bit ? {const_field[30], const_field}
                       : {{(32-`LMX_SHORT_CON_W+1){const_field[30]}},
                          const_field[`LMX_SHORT_CON_W-2:0]};          // [RULE_15]

   // Type field from D13..D12 of the long format, else from short code
   always_comb
   begin
      logic [1:0] tf;
      logic [1:0] dd;
      tf = short_type;
      dd = dis_field[`LMX_TYPE_MSB:`LMX_TYPE_LSB];                      // [RULE_03]
      if (e_bit)
      begin
         tf = dd;
      end
      case (tf)
         2'h0:    dtype = dis_field[0] ? lmx_pkg::LMX_DT_BS : lmx_pkg::LMX_DT_BU;
         2'h1:    dtype = dis_field[0] ? lmx_pkg::LMX_DT_HS : lmx_pkg::LMX_DT_HU;
         2'h2:    dtype = lmx_pkg::LMX_DT_W;
         default: dtype = lmx_pkg::LMX_DT_D;
      endcase
   end

   // Status register as source of a pair move reads as zero
   assign src_val = (op_code == lmx_pkg::LMX_OP_COPY_PAIR_OP && src_idx == {1'b0, `LMX_REG_SR})
                    ? 32'h0000_0000 : ra_data;                          // [RULE_18]
   assign dst_val = rb_data;
   assign sprod   = $signed(dst_val) * $signed(src_val);               // [RULE_21]
   assign uprod   = dst_val * src_val;

   lmx_regfile u_regs
   (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .wb       (wb),
      .ra_idx   (src_idx),
      .rb_idx   (dst_idx),
      .rc_idx   (srcf_idx),
      .ra_data  (ra_data),
      .rb_data  (rb_data),
      .rc_data  (rc_data)
   );

   assign wb.we   = wb_we;
   assign wb.idx  = wb_idx;
   assign wb.data = wb_data;

   // Narrow loads extended to 32 bits
   function automatic logic [31:0] extend(input lmx_pkg::lmx_dtype_e t, input logic [31:0] d);
      case (t)
         lmx_pkg::LMX_DT_BU: extend = {24'h000000, d[7:0]};                // [RULE_24]
         lmx_pkg::LMX_DT_BS: extend = {{24{d[7]}}, d[7:0]};                // [RULE_24]
         lmx_pkg::LMX_DT_HU: extend = {16'h0000, d[15:0]};                 // [RULE_24]
         lmx_pkg::LMX_DT_HS: extend = {{16{d[15]}}, d[15:0]};              // [RULE_24]
         default:            extend = d;
      endcase
   endfunction

   always_comb
   begin
      next_state   = state;
      next_op_q    = op_q;
      next_dt_q    = dt_q;
      next_tgt_q   = tgt_q;
      next_addr_q  = addr_q;
      next_io_q    = io_q;
      next_hold_q  = hold_q;
      next_hidx_q  = hidx_q;
      next_flags   = flags;
      next_ret_req = 1'b0;
      next_ret_pc  = ret_pc;
      next_ret_sr  = ret_sr;
      wb_we        = 1'b0;
      wb_idx       = 5'h00;
      wb_data      = 32'h0000_0000;
      case (state)
         lmx_pkg::LMX_ST_IDLE:
         begin
            if (op_valid)
            begin
               next_op_q  = op_code;
               next_tgt_q = src_idx;
               next_dt_q  = lmx_pkg::LMX_DT_W;
               next_io_q  = 1'b0;
               next_addr_q = dst_val;
               case (op_code)
                  lmx_pkg::LMX_OP_IOA, lmx_pkg::LMX_OP_IOD:
                  begin
                     next_io_q = 1'b1;
                     next_dt_q = (dtype == lmx_pkg::LMX_DT_D) ? lmx_pkg::LMX_DT_D
                                                             : lmx_pkg::LMX_DT_W; // [RULE_06]
                     if (dst_idx == {1'b0, `LMX_REG_SR})
                     begin
                        next_addr_q = dis;                                    // [RULE_04]
                     end
                     else
                     begin
                        next_addr_q = dst_val + dis;                          // [RULE_05]
                     end
                     next_state = lmx_pkg::LMX_ST_RD1;
                  end
                  lmx_pkg::LMX_OP_NEXT:
                  begin
                     next_dt_q = dtype;                                       // [RULE_09]
                     wb_we     = 1'b1;
                     wb_idx    = dst_idx;
                     // Base bumped in the issue cycle, before memory answers
                     if (dtype == lmx_pkg::LMX_DT_BU || dtype == lmx_pkg::LMX_DT_BS)
                     begin
                        wb_data = dst_val + dis;                              // [RULE_07]
                     end
                     else
                     begin
                        wb_data = dst_val + {dis[31:1], 1'b0};                // [RULE_08]
                     end
                     next_state = lmx_pkg::LMX_ST_RD1;
                  end
                  lmx_pkg::LMX_OP_POSTW:
                  begin
                     wb_we      = 1'b1;
                     wb_idx     = dst_idx;
                     wb_data    = dst_val + `LMX_WORD_STEP;                    // [RULE_10]
                     next_state = lmx_pkg::LMX_ST_RD1;
                  end
                  lmx_pkg::LMX_OP_INDW:
                  begin
                     next_state = lmx_pkg::LMX_ST_RD1;                        // [RULE_11]
                  end
                  lmx_pkg::LMX_OP_STACKW:
                  begin
                     wb_we      = 1'b1;
                     wb_idx     = dst_idx;
                     wb_data    = dst_val + dis;                              // [RULE_13]
                     next_state = lmx_pkg::LMX_ST_RD1;
                  end
                  lmx_pkg::LMX_OP_MASK:
                  begin
                     wb_we   = 1'b1;
                     wb_idx  = dst_idx;
                     wb_data = src_val & cval;                                // [RULE_14]
                     next_flags[`LMX_FLAG_Z] = (wb_data == 32'h0000_0000);    // [RULE_14]
                  end
                  lmx_pkg::LMX_OP_MOV:
                  begin
                     wb_we   = 1'b1;
                     wb_idx  = dst_idx;
                     wb_data = src_val;                                       // [RULE_16]
                     next_flags[`LMX_FLAG_Z] = (src_val == 32'h0000_0000);
                     next_flags[`LMX_FLAG_N] = src_val[31];                   // [RULE_16]
                  end
                  lmx_pkg::LMX_OP_COPY_PAIR_OP:
                  begin
                     if (dst_idx == {1'b0, `LMX_REG_PC})
                     begin
                        next_ret_req = 1'b1;                                  // [RULE_18]
                        next_ret_pc  = src_val;
                        next_ret_sr  = (src_idx == {1'b0, `LMX_REG_SR}) ? 32'h0000_0000
                                                                        : rc_data;
                     end
                     else
                     begin
                        wb_we       = 1'b1;
                        wb_idx      = dst_idx;
                        wb_data     = src_val;                                // [RULE_17]
                        next_hold_q = (src_idx == {1'b0, `LMX_REG_SR}) ? 32'h0000_0000
                                                                       : rc_data;
                        next_hidx_q = dstf_idx;
                        next_flags[`LMX_FLAG_Z] = ({src_val, next_hold_q} == 64'h0);
                        next_flags[`LMX_FLAG_N] = src_val[31];                // [RULE_17]
                        next_state  = lmx_pkg::LMX_ST_WR2;
                     end
                  end
                  lmx_pkg::LMX_OP_COPY_IMMEDIATE_OP:
                  begin
                     wb_we   = 1'b1;
                     wb_idx  = dst_idx;
                     wb_data = imm_value;                                     // [RULE_19]
                     next_flags[`LMX_FLAG_Z] = (imm_value == 32'h0000_0000);
                     next_flags[`LMX_FLAG_N] = imm_value[31];
                     next_flags[`LMX_FLAG_V] = 1'b0;                          // [RULE_19]
                  end
                  lmx_pkg::LMX_OP_MUL:
                  begin
                     wb_we   = 1'b1;
                     wb_idx  = dst_idx;
                     wb_data = uprod[31:0];                                   // [RULE_20]
                     next_flags[`LMX_FLAG_Z] = (uprod[31:0] == 32'h0000_0000);
                     next_flags[`LMX_FLAG_N] = uprod[31];                     // [RULE_20]
                  end
                  lmx_pkg::LMX_OP_SIGNED_WIDE_PRODUCT_OP:
                  begin
                     wb_we       = 1'b1;
                     wb_idx      = dst_idx;
                     wb_data     = sprod[63:32];                              // [RULE_21]
                     next_hold_q = sprod[31:0];
                     next_hidx_q = dstf_idx;
                     next_flags[`LMX_FLAG_Z] = (sprod == 64'h0);              // [RULE_23]
                     next_flags[`LMX_FLAG_N] = sprod[63];                     // [RULE_23]
                     next_state  = lmx_pkg::LMX_ST_WR2;
                  end
                  default:
                  begin
                     next_state = lmx_pkg::LMX_ST_IDLE;
                  end
               endcase
            end
         end
         lmx_pkg::LMX_ST_RD1:
         begin
            if (mem_ack)
            begin
               wb_we   = 1'b1;
               wb_idx  = tgt_q;
               wb_data = extend(dt_q, mem_rdata);                             // [RULE_24]
               if (dt_q == lmx_pkg::LMX_DT_D)
               begin
                  next_addr_q = addr_q + `LMX_WORD_STEP;                      // [RULE_06] [RULE_07]
                  next_tgt_q  = {tgt_q[4], 4'(tgt_q[3:0] + 4'h1)};
                  next_state  = lmx_pkg::LMX_ST_RD2;
               end
               else
               begin
                  next_state = lmx_pkg::LMX_ST_DONE;
               end
            end
         end
         lmx_pkg::LMX_ST_RD2:
         begin
            if (mem_ack)
            begin
               wb_we      = 1'b1;
               wb_idx     = tgt_q;
               wb_data    = mem_rdata;
               next_state = lmx_pkg::LMX_ST_DONE;
            end
         end
         lmx_pkg::LMX_ST_WR2:
         begin
            wb_we      = 1'b1;
            wb_idx     = hidx_q;
            wb_data    = hold_q;
            next_state = lmx_pkg::LMX_ST_IDLE;
         end
         lmx_pkg::LMX_ST_DONE:
         begin
            next_state = lmx_pkg::LMX_ST_IDLE;
         end
         default:
         begin
            next_state = lmx_pkg::LMX_ST_IDLE;
         end
      endcase
   end

   assign busy     = (state != lmx_pkg::LMX_ST_IDLE);
   assign mem_req  = (state == lmx_pkg::LMX_ST_RD1) || (state == lmx_pkg::LMX_ST_RD2);
   assign mem_io   = io_q;
   assign mem_addr = addr_q;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state   <= lmx_pkg::LMX_ST_IDLE;
         op_q    <= lmx_pkg::LMX_OP_NONE;
         dt_q    <= lmx_pkg::LMX_DT_W;
         tgt_q   <= 5'h00;
         addr_q  <= 32'h0000_0000;
         io_q    <= 1'b0;
         hold_q  <= 32'h0000_0000;
         hidx_q  <= 5'h00;
         flags   <= 3'h0;
         ret_req <= 1'b0;
         ret_pc  <= 32'h0000_0000;
         ret_sr  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         state   <= next_state;
         op_q    <= next_op_q;
         dt_q    <= next_dt_q;
         tgt_q   <= next_tgt_q;
         addr_q  <= next_addr_q;
         io_q    <= next_io_q;
         hold_q  <= next_hold_q;
         hidx_q  <= next_hidx_q;
         flags   <= next_flags;
         ret_req <= next_ret_req;
         ret_pc  <= next_ret_pc;
         ret_sr  <= next_ret_sr;
      end
   end
endmodule

// file: testbench/lmx_exec_sva.sv
// Purpose: Port checks for lmx_exec
// Assumes: Flags settle one edge after issue
// Notes:   Attached by bind to every lmx_exec
`timescale 1ns/1ps
`include "lmx_regs.svh"
module lmx_exec_chk
(
   input wire logic             core_clk,
   input wire logic             resetn,
   input wire logic             clk_en,
   input wire logic             op_valid,
   input wire lmx_pkg::lmx_op_e op_code,
   input wire logic             d_bit,
   input wire logic             e_bit,
   input wire logic [3:0]       rd_code,
   input wire logic [27:0]      dis_field,
   input wire logic [31:0]      imm_value,
   input wire logic             busy,
   input wire logic             mem_req,
   input wire logic             mem_io,
   input wire logic [31:0]      mem_addr,
   input wire logic             mem_ack,
   input wire logic [2:0]       flags,
   input wire logic             ret_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic        take, io_op, ld_op;
   logic [2:0]  imm_flg;
   logic [31:0] short_dis;
   assign take = op_valid && clk_en && !busy;
   assign io_op = op_code == lmx_pkg::LMX_OP_IOA || op_code == lmx_pkg::LMX_OP_IOD;
   assign ld_op = op_code >= lmx_pkg::LMX_OP_IOA && op_code <= lmx_pkg::LMX_OP_STACKW;
   assign imm_flg = {1'b0, imm_value[31], imm_value == 32'h0};
   assign short_dis = {{20{dis_field[27]}}, dis_field[11:0]};
   load_req_a: assert property (take && ld_op |=> mem_req)
      else $error("load issued without memory request");
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req)
      else $error("memory request dropped early");
   addr_hold_a: assert property (mem_req && !mem_ack |=> $stable(mem_addr))
      else $error("memory address moved while waiting");
   io_space_a: assert property (take && ld_op |=> mem_io == $past(io_op))
      else $error("address space select wrong");
   io_abs_a: assert property (
      take && op_code == lmx_pkg::LMX_OP_IOA && !e_bit |=> mem_addr == $past(short_dis))
      else $error("absolute address wrong");
   imm_flags_a: assert property (
      take && op_code == lmx_pkg::LMX_OP_COPY_IMMEDIATE_OP ##1 !op_valid |=> flags == $past(imm_flg, 2))
      else $error("immediate move flags wrong");
   ret_start_a: assert property (
      take && op_code == lmx_pkg::LMX_OP_COPY_PAIR_OP && !d_bit && rd_code == `LMX_REG_PC
      |-> ##[1:3] ret_req)
      else $error("return not started");
   ret_pulse_a: assert property (ret_req |=> !ret_req)
      else $error("return pulse too long");
   no_mem_alu_a: assert property (take && op_code >= lmx_pkg::LMX_OP_MASK |=> !mem_req)
      else $error("register operation touched memory");
   ret_c: cover property (ret_req);
   io_c: cover property (mem_req && mem_ack && mem_io);
   zero_c: cover property ($rose(flags[`LMX_FLAG_Z]));
endmodule

bind lmx_exec lmx_exec_chk i_lmx_exec_chk (.core_clk, .resetn, .clk_en, .op_valid, .op_code,
   .d_bit, .e_bit, .rd_code, .dis_field, .imm_value, .busy, .mem_req, .mem_io, .mem_addr,
   .mem_ack, .flags, .ret_req);

// file: testbench/tb.sv
// Purpose: Self-checking bench for lmx_exec
// Assumes: Registers start at zero; read back by pair return
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "lmx_regs.svh"
module tb;
   logic             core_clk, resetn, clk_en, op_valid, s_bit, d_bit, e_bit, mem_ack;
   logic             busy, mem_req, mem_io, ret_req;
   lmx_pkg::lmx_op_e op_code;
   logic [3:0]       rs_code, rd_code;
   logic [27:0]      dis_field;
   logic [30:0]      const_field;
   logic [1:0]       short_type;
   logic [2:0]       flags;
   logic [31:0]      imm_value, mem_rdata, mem_addr, ret_pc, ret_sr;
   int               miscompares, checks_done, cycles;

   lmx_exec i_lmx_exec (.core_clk, .resetn, .clk_en, .op_valid, .op_code, .s_bit, .d_bit,
      .e_bit, .rs_code, .rd_code, .dis_field, .const_field, .short_type, .imm_value, .busy,
      .mem_req, .mem_io, .mem_addr, .mem_ack, .mem_rdata, .flags, .ret_req, .ret_pc, .ret_sr);

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic report_and_stop;
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step;
      @(posedge core_clk);
      #1;
   endtask

   task automatic idle;
      while (busy)
         step;
      step;
      step;
   endtask

   task automatic fl(input logic [2:0] m, e);
      chk({29'h0, flags & m}, {29'h0, e});
   endtask

   // Issue one operation; sde holds s, d and e bits
   task automatic op(input lmx_pkg::lmx_op_e c, input logic [2:0] sde, input logic [3:0] rs, rd);
      {s_bit, d_bit, e_bit, rs_code, rd_code} = {sde, rs, rd};
      op_code = c;
      op_valid = 1'b1;
      step;
      op_valid = 1'b0;
   endtask

   task automatic mem(input logic [31:0] addr, input logic io, input logic [31:0] data);
      step;
      while (!mem_req)
         step;
      chk(mem_addr, addr);
      chk({31'h0, mem_io}, {31'h0, io});
      {mem_ack, mem_rdata} = {1'b1, data};
      step;
      {mem_ack, mem_rdata} = {1'b0, ~data};
   endtask

   task automatic setr(input logic d, input logic [3:0] rd, input logic [31:0] v);
      imm_value = v;
      op(lmx_pkg::LMX_OP_COPY_IMMEDIATE_OP, {1'b0, d, 1'b0}, 4'h0, rd);
      idle;
   endtask

   // Pair move to the counter exposes a register pair
   task automatic see(input logic s, input logic [3:0] rs, input logic [31:0] hi, lo);
      op(lmx_pkg::LMX_OP_COPY_PAIR_OP, {s, 2'b00}, rs, `LMX_REG_PC);
      repeat (3)
         if (!ret_req)
            step;
      chk({31'h0, ret_req}, 32'h1);
      chk(ret_pc, hi);
      chk(ret_sr, lo);
      idle;
   endtask

   task automatic t_move;
      setr(1'b0, 4'h2, 32'h8000_4000);
      fl(3'h7, 3'h2);
      setr(1'b1, 4'h2, 32'h0);
      fl(3'h7, 3'h1);
      op(lmx_pkg::LMX_OP_MOV, 3'b010, 4'h2, 4'h5);
      idle;
      fl(3'h3, 3'h2);
      see(1'b1, 4'h5, 32'h8000_4000, 32'h0);
   endtask

   task automatic t_mask;
      const_field = 31'h4000_0000;
      op(lmx_pkg::LMX_OP_MASK, 3'b010, 4'h2, 4'h7);
      idle;
      fl(3'h1, 3'h0);
      const_field = 31'h0000_4000;
      op(lmx_pkg::LMX_OP_MASK, 3'b011, 4'h2, 4'h8);
      idle;
      see(1'b1, 4'h7, 32'h8000_4000, 32'h0000_4000);
   endtask

   task automatic t_pair;
      op(lmx_pkg::LMX_OP_COPY_PAIR_OP, 3'b100, 4'h7, 4'h5);
      idle;
      fl(3'h3, 3'h2);
      see(1'b0, 4'h5, 32'h8000_4000, 32'h0000_4000);
      op(lmx_pkg::LMX_OP_COPY_PAIR_OP, 3'b000, `LMX_REG_SR, 4'h5);
      idle;
      fl(3'h1, 3'h1);
      see(1'b0, 4'h5, 32'h0, 32'h0);
   endtask

   task automatic t_mul;
      setr(1'b1, 4'h3, 32'h0001_0000);
      setr(1'b1, 4'h4, 32'h0001_0000);
      op(lmx_pkg::LMX_OP_MUL, 3'b110, 4'h4, 4'h3);
      idle;
      fl(3'h3, 3'h1);
      setr(1'b1, 4'h3, 32'h0001_0000);
      op(lmx_pkg::LMX_OP_SIGNED_WIDE_PRODUCT_OP, 3'b110, 4'h4, 4'h3);
      idle;
      fl(3'h3, 3'h0);
      see(1'b1, 4'h3, 32'h1, 32'h0);
      setr(1'b1, 4'h3, 32'hFFFF_FFFF);
      op(lmx_pkg::LMX_OP_SIGNED_WIDE_PRODUCT_OP, 3'b110, 4'h8, 4'h3);
      idle;
      fl(3'h3, 3'h2);
      see(1'b1, 4'h3, 32'hFFFF_FFFF, 32'hFFFF_C000);
   endtask

   task automatic t_load;
      setr(1'b1, 4'h1, 32'h0000_1000);
      op(lmx_pkg::LMX_OP_INDW, 3'b000, 4'h3, 4'h1);
      mem(32'h1000, 1'b0, 32'h1234_5678);
      idle;
      op(lmx_pkg::LMX_OP_POSTW, 3'b000, 4'h4, 4'h1);
      mem(32'h1000, 1'b0, 32'hCAFE_0001);
      idle;
      see(1'b0, 4'h3, 32'h1234_5678, 32'hCAFE_0001);
      dis_field = 28'h800_0FF0;
      op(lmx_pkg::LMX_OP_STACKW, 3'b010, 4'h3, 4'h1);
      mem(32'h1004, 1'b0, 32'h0);
      idle;
      {short_type, dis_field} = {2'h0, 28'h3};
      op(lmx_pkg::LMX_OP_NEXT, 3'b010, 4'h3, 4'h1);
      mem(32'h0FF4, 1'b0, 32'h8080_8080);
      idle;
      {short_type, dis_field} = {2'h1, 28'h2};
      op(lmx_pkg::LMX_OP_NEXT, 3'b010, 4'h4, 4'h1);
      mem(32'h0FF7, 1'b0, 32'h8080_8080);
      idle;
      see(1'b0, 4'h3, 32'hFFFF_FF80, 32'h0000_8080);
      dis_field = 28'h000_2005;
      op(lmx_pkg::LMX_OP_NEXT, 3'b011, 4'h3, 4'h1);
      mem(32'h0FF9, 1'b0, 32'h5);
      idle;
      dis_field = 28'h000_3008;
      op(lmx_pkg::LMX_OP_NEXT, 3'b011, 4'h3, 4'h1);
      mem(32'h2FFD, 1'b0, 32'h6);
      mem(32'h3001, 1'b0, 32'h7);
      idle;
      {short_type, dis_field} = {2'h2, 28'h800_0FF0};
      op(lmx_pkg::LMX_OP_IOA, 3'b000, 4'h3, `LMX_REG_SR);
      mem(32'hFFFF_FFF0, 1'b1, 32'h8);
      idle;
      dis_field = 28'h000_3010;
      op(lmx_pkg::LMX_OP_IOD, 3'b011, 4'h3, 4'h1);
      mem(32'h0000_9015, 1'b1, 32'h9);
      mem(32'h0000_9019, 1'b1, 32'hA);
      idle;
      see(1'b0, 4'h3, 32'h9, 32'hA);
   endtask

   initial
   begin
      {resetn, clk_en, op_valid, mem_ack, s_bit, d_bit, e_bit} = 7'b0100000;
      {rs_code, rd_code, short_type, dis_field, const_field, imm_value, mem_rdata} = '0;
      op_code = lmx_pkg::LMX_OP_NONE;
      repeat (3)
         step;
      resetn = 1'b1;
      chk({28'h0, busy, mem_req, ret_req, mem_io}, 32'h0);
      chk({29'h0, flags}, 32'h0);
      t_move;
      t_mask;
      t_pair;
      t_mul;
      t_load;
      report_and_stop;
   end
endmodule
